// ==== src/split_timer_pkg.sv ====
// constants shared by the split reload timer and its helpers
package split_timer_pkg;
    // byte addresses on the register bus
    localparam logic [7:0] TIMER_CONTROL_OFF    = 8'hC8;
    localparam logic [7:0] TIMER_COUNT_LOW_OFF  = 8'hCC;
    localparam logic [7:0] TIMER_COUNT_HIGH_OFF = 8'hD0;
    localparam logic [7:0] RELOAD_LOW_OFF       = 8'hD4;
    localparam logic [7:0] RELOAD_HIGH_OFF      = 8'hD8;
    localparam logic [7:0] CLOCK_SELECT_OFF     = 8'hDC;
    localparam logic [7:0] IRQ_STATUS_OFF       = 8'hE0;
    localparam logic [7:0] IRQ_MASK_OFF         = 8'hE4;
    // control register fields
    localparam int HIGH_OVF_BIT   = 7;
    localparam int LOW_OVF_BIT    = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int CAPTURE_EN_BIT = 4;
    localparam int SPLIT_BIT      = 3;
    localparam int RUN_BIT        = 2;
    localparam int EXT_CLK_BIT    = 0;
    // clock select register fields
    localparam int LOW_CLK_SEL_BIT  = 0;
    localparam int HIGH_CLK_SEL_BIT = 1;
    // interrupt status and mask fields
    localparam int EV_HIGH_OVF = 0;
    localparam int EV_LOW_OVF  = 1;
    localparam int EV_CAPTURE  = 2;
    localparam int EV_COUNT    = 3;
    // reset values
    localparam logic [7:0]          CONTROL_RESET = 8'h00;
    localparam logic [7:0]          COUNT_RESET   = 8'h00;
    localparam logic [7:0]          RELOAD_RESET  = 8'h00;
    localparam logic [1:0]          CLKSEL_RESET  = 2'h0;
    localparam logic [EV_COUNT-1:0] IRQ_RESET     = 3'h0;
    // timing counts
    localparam logic [3:0] SYS_DIV_LAST = 4'hB;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;
    localparam logic [7:0] BYTE_MAX     = 8'hFF;
endpackage : split_timer_pkg

// ==== src/tick_if.sv ====
// count clock enables passed from the divider to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic sys12_tick;
    logic ext8_tick;
    modport src (output sys12_tick, output ext8_tick);
    modport dst (input sys12_tick, input ext8_tick);
endinterface : tick_if
`default_nettype wire

// ==== src/fall_detect.sv ====
// two-stage synchroniser with falling edge pulse for the capture pin
`timescale 1ns/1ps
`default_nettype none
module fall_detect (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // pin and pulse
    input  wire logic pin,
    output logic      fall
);
    logic meta_q, sync_q, prev_q;
    logic meta_d, sync_d, prev_d;

    always_comb begin
        meta_d = pin;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // first stage feeds the second stage only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign fall = prev_q & ~sync_q;
endmodule : fall_detect
`default_nettype wire

// ==== src/tick_gen.sv ====
// divide-by-12 system tick and divide-by-8 external clock tick
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // external oscillator pin
    input  wire logic ext_osc_clk,
    // ticks out
    tick_if.src       ticks
);
    logic [3:0] sys_cnt_q, sys_cnt_d;
    logic [2:0] ext_cnt_q, ext_cnt_d;
    logic       meta_q, sync_q, prev_q;
    logic       ext_rise;

    // edges are found on ref_clk, so a slow oscillator counts once per edge
    assign ext_rise = sync_q & ~prev_q;

    always_comb begin
        sys_cnt_d = (sys_cnt_q == split_timer_pkg::SYS_DIV_LAST)
                  ? 4'h0 : 4'(sys_cnt_q + 4'h1);
        ext_cnt_d = ext_rise ? 3'(ext_cnt_q + 3'h1) : ext_cnt_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_cnt_q <= 4'h0;
            ext_cnt_q <= 3'h0;
            meta_q    <= 1'b0;
            sync_q    <= 1'b0;
            prev_q    <= 1'b0;
        end else begin
            sys_cnt_q <= sys_cnt_d;
            ext_cnt_q <= ext_cnt_d;
            meta_q    <= ext_osc_clk;
            sync_q    <= meta_q;
            prev_q    <= sync_q;
        end
    end

    assign ticks.sys12_tick = (sys_cnt_q == split_timer_pkg::SYS_DIV_LAST);
    assign ticks.ext8_tick  = ext_rise
                            & (ext_cnt_q == split_timer_pkg::EXT_DIV_LAST);
endmodule : tick_gen
`default_nettype wire

// ==== src/split_reload_timer.sv ====
// auto-reload timer, one 16-bit or two 8-bit, with capture and irq
`timescale 1ns/1ps
`default_nettype none
module split_reload_timer (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // pins
    input  wire logic        ext_osc_clk,
    input  wire logic        capture_input_pin,
    // interrupt
    output logic             irq
);
    localparam int NEV = split_timer_pkg::EV_COUNT;

    tick_if ticks ();

    logic cap_fall;

    tick_gen u_tick_gen (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .ext_osc_clk (ext_osc_clk),
        .ticks       (ticks.src)
    );

    fall_detect u_fall_detect (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (capture_input_pin),
        .fall    (cap_fall)
    );

    // control state
    logic           high_overflow_flag_q,      high_overflow_flag_d;
    logic           low_overflow_flag_q,       low_overflow_flag_d;
    logic           low_overflow_irq_enable_q, low_overflow_irq_enable_d;
    logic           capture_enable_q,          capture_enable_d;
    logic           split_mode_enable_q,       split_mode_enable_d;
    logic           run_control_q,             run_control_d;
    logic           external_clock_select_q,   external_clock_select_d;
    logic [1:0]     clock_select_register_q,   clock_select_register_d;
    // count and reload state
    logic [7:0]     counter_low_byte_q,  counter_low_byte_d;
    logic [7:0]     counter_high_byte_q, counter_high_byte_d;
    logic [7:0]     reload_low_byte_q,   reload_low_byte_d;
    logic [7:0]     reload_high_byte_q,  reload_high_byte_d;
    // interrupt state
    logic [NEV-1:0] irq_status_q, irq_status_d;
    logic [NEV-1:0] irq_mask_q,   irq_mask_d;
    // bus state
    logic           ack_q,      ack_d;
    logic [31:0]    readdata_q, readdata_d;

    // decoded access and events
    logic           wr_en;
    logic           low_tick;
    logic           high_tick;
    logic           lo_ovf;
    logic           hi_ovf;
    logic           cap_ev;
    logic [NEV-1:0] events;
    logic [NEV-1:0] irq_gate;
    logic [7:0]     control_rd;
    logic [15:0]    count16;

    // one wait cycle per access; the write lands on the released edge
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_en       = write & ack_q & byteenable[0];
    assign readdata    = readdata_q;
    assign count16     = {counter_high_byte_q, counter_low_byte_q};

    always_comb begin
        if (clock_select_register_q[split_timer_pkg::LOW_CLK_SEL_BIT]) begin
            low_tick = 1'b1;
        end else if (external_clock_select_q) begin
            low_tick = ticks.ext8_tick;
        end else begin
            low_tick = ticks.sys12_tick;
        end
        if (clock_select_register_q[split_timer_pkg::HIGH_CLK_SEL_BIT]) begin
            high_tick = 1'b1;
        end else if (external_clock_select_q) begin
            high_tick = ticks.ext8_tick;
        end else begin
            high_tick = ticks.sys12_tick;
        end
    end

    // reserved bit 1 always reads zero
    always_comb begin
        control_rd = split_timer_pkg::CONTROL_RESET;
        control_rd[split_timer_pkg::HIGH_OVF_BIT]   = high_overflow_flag_q;
        control_rd[split_timer_pkg::LOW_OVF_BIT]    = low_overflow_flag_q;
        control_rd[split_timer_pkg::LOW_IRQ_EN_BIT] =
            low_overflow_irq_enable_q;
        control_rd[split_timer_pkg::CAPTURE_EN_BIT] = capture_enable_q;
        control_rd[split_timer_pkg::SPLIT_BIT]      = split_mode_enable_q;
        control_rd[split_timer_pkg::RUN_BIT]        = run_control_q;
        control_rd[split_timer_pkg::EXT_CLK_BIT]    = external_clock_select_q;
    end

    // counting, reload and capture
    always_comb begin
        counter_low_byte_d  = counter_low_byte_q;
        counter_high_byte_d = counter_high_byte_q;
        reload_low_byte_d   = reload_low_byte_q;
        reload_high_byte_d  = reload_high_byte_q;
        lo_ovf              = 1'b0;
        hi_ovf              = 1'b0;
        if (!split_mode_enable_q) begin
            if (run_control_q && low_tick) begin
                if (count16 == {split_timer_pkg::BYTE_MAX,
                                split_timer_pkg::BYTE_MAX}) begin
                    counter_low_byte_d  = reload_low_byte_q;
                    counter_high_byte_d = reload_high_byte_q;
                    hi_ovf              = 1'b1;
                    lo_ovf              = 1'b1;
                end else begin
                    {counter_high_byte_d, counter_low_byte_d} =
                        16'(count16 + 16'h0001);
                    lo_ovf = (counter_low_byte_q
                              == split_timer_pkg::BYTE_MAX);
                end
            end
        end else begin
            // low byte ignores the run bit in split mode
            if (low_tick) begin
                if (counter_low_byte_q == split_timer_pkg::BYTE_MAX) begin
                    counter_low_byte_d = reload_low_byte_q;
                    lo_ovf             = 1'b1;
                end else begin
                    counter_low_byte_d = 8'(counter_low_byte_q + 8'h01);
                end
            end
            if (run_control_q && high_tick) begin
                if (counter_high_byte_q == split_timer_pkg::BYTE_MAX) begin
                    counter_high_byte_d = reload_high_byte_q;
                    hi_ovf              = 1'b1;
                end else begin
                    counter_high_byte_d = 8'(counter_high_byte_q + 8'h01);
                end
            end
        end
        // software writes to the count win over the same-cycle count step
        if (wr_en && address == split_timer_pkg::TIMER_COUNT_LOW_OFF) begin
            counter_low_byte_d = writedata[7:0];
        end
        if (wr_en && address == split_timer_pkg::TIMER_COUNT_HIGH_OFF) begin
            counter_high_byte_d = writedata[7:0];
        end
        // capture wins over a software reload write in the same cycle
        cap_ev = cap_fall & capture_enable_q;
        if (cap_ev) begin
            reload_low_byte_d  = counter_low_byte_q;
            reload_high_byte_d = counter_high_byte_q;
        end else begin
            if (wr_en && address == split_timer_pkg::RELOAD_LOW_OFF) begin
                reload_low_byte_d = writedata[7:0];
            end
            if (wr_en && address == split_timer_pkg::RELOAD_HIGH_OFF) begin
                reload_high_byte_d = writedata[7:0];
            end
        end
    end

    // control register, flags and clock select
    always_comb begin
        high_overflow_flag_d      = high_overflow_flag_q;
        low_overflow_flag_d       = low_overflow_flag_q;
        low_overflow_irq_enable_d = low_overflow_irq_enable_q;
        capture_enable_d          = capture_enable_q;
        split_mode_enable_d       = split_mode_enable_q;
        run_control_d             = run_control_q;
        external_clock_select_d   = external_clock_select_q;
        clock_select_register_d   = clock_select_register_q;
        if (wr_en && address == split_timer_pkg::TIMER_CONTROL_OFF) begin
            high_overflow_flag_d =
                writedata[split_timer_pkg::HIGH_OVF_BIT];
            low_overflow_flag_d =
                writedata[split_timer_pkg::LOW_OVF_BIT];
            low_overflow_irq_enable_d =
                writedata[split_timer_pkg::LOW_IRQ_EN_BIT];
            capture_enable_d =
                writedata[split_timer_pkg::CAPTURE_EN_BIT];
            split_mode_enable_d =
                writedata[split_timer_pkg::SPLIT_BIT];
            run_control_d =
                writedata[split_timer_pkg::RUN_BIT];
            external_clock_select_d =
                writedata[split_timer_pkg::EXT_CLK_BIT];
            // the reserved bit is not stored, so a stray one is harmless
        end
        if (wr_en && address == split_timer_pkg::CLOCK_SELECT_OFF) begin
            clock_select_register_d = writedata[1:0];
        end
        // hardware only sets; a set beats a same-cycle software clear
        if (hi_ovf) begin
            high_overflow_flag_d = 1'b1;
        end
        if (lo_ovf) begin
            low_overflow_flag_d = 1'b1;
        end
    end

    // interrupt status, mask and qualified output
    always_comb begin
        events                                = '0;
        events[split_timer_pkg::EV_HIGH_OVF]  = hi_ovf;
        events[split_timer_pkg::EV_LOW_OVF]   = lo_ovf;
        events[split_timer_pkg::EV_CAPTURE]   = cap_ev;
        irq_status_d = irq_status_q;
        irq_mask_d   = irq_mask_q;
        if (wr_en && address == split_timer_pkg::IRQ_STATUS_OFF) begin
            irq_status_d = irq_status_q & ~writedata[NEV-1:0];
        end
        if (wr_en && address == split_timer_pkg::IRQ_MASK_OFF) begin
            irq_mask_d = writedata[NEV-1:0];
        end
        irq_status_d = irq_status_d | events;
        // low overflow also needs its own enable in the control register
        irq_gate                              = irq_mask_q;
        irq_gate[split_timer_pkg::EV_LOW_OVF] =
            irq_mask_q[split_timer_pkg::EV_LOW_OVF]
            & low_overflow_irq_enable_q;
    end

    assign irq = |(irq_status_q & irq_gate);

    // bus answer
    always_comb begin
        ack_d      = (read | write) & ~ack_q;
        readdata_d = readdata_q;
        if (read && !ack_q) begin
            unique case (address)
                split_timer_pkg::TIMER_CONTROL_OFF:
                    readdata_d = {24'h000000, control_rd};
                split_timer_pkg::TIMER_COUNT_LOW_OFF:
                    readdata_d = {24'h000000, counter_low_byte_q};
                split_timer_pkg::TIMER_COUNT_HIGH_OFF:
                    readdata_d = {24'h000000, counter_high_byte_q};
                split_timer_pkg::RELOAD_LOW_OFF:
                    readdata_d = {24'h000000, reload_low_byte_q};
                split_timer_pkg::RELOAD_HIGH_OFF:
                    readdata_d = {24'h000000, reload_high_byte_q};
                split_timer_pkg::CLOCK_SELECT_OFF:
                    readdata_d = {30'h0, clock_select_register_q};
                split_timer_pkg::IRQ_STATUS_OFF:
                    readdata_d = {29'h0, irq_status_q};
                split_timer_pkg::IRQ_MASK_OFF:
                    readdata_d = {29'h0, irq_mask_q};
                default:
                    readdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_overflow_flag_q      <= 1'b0;
            low_overflow_flag_q       <= 1'b0;
            low_overflow_irq_enable_q <= 1'b0;
            capture_enable_q          <= 1'b0;
            split_mode_enable_q       <= 1'b0;
            run_control_q             <= 1'b0;
            external_clock_select_q   <= 1'b0;
            clock_select_register_q   <= split_timer_pkg::CLKSEL_RESET;
            counter_low_byte_q        <= split_timer_pkg::COUNT_RESET;
            counter_high_byte_q       <= split_timer_pkg::COUNT_RESET;
            reload_low_byte_q         <= split_timer_pkg::RELOAD_RESET;
            reload_high_byte_q        <= split_timer_pkg::RELOAD_RESET;
            irq_status_q              <= split_timer_pkg::IRQ_RESET;
            irq_mask_q                <= split_timer_pkg::IRQ_RESET;
            ack_q                     <= 1'b0;
            readdata_q                <= 32'h00000000;
        end else begin
            high_overflow_flag_q      <= high_overflow_flag_d;
            low_overflow_flag_q       <= low_overflow_flag_d;
            low_overflow_irq_enable_q <= low_overflow_irq_enable_d;
            capture_enable_q          <= capture_enable_d;
            split_mode_enable_q       <= split_mode_enable_d;
            run_control_q             <= run_control_d;
            external_clock_select_q   <= external_clock_select_d;
            clock_select_register_q   <= clock_select_register_d;
            counter_low_byte_q        <= counter_low_byte_d;
            counter_high_byte_q       <= counter_high_byte_d;
            reload_low_byte_q         <= reload_low_byte_d;
            reload_high_byte_q        <= reload_high_byte_d;
            irq_status_q              <= irq_status_d;
            irq_mask_q                <= irq_mask_d;
            ack_q                     <= ack_d;
            readdata_q                <= readdata_d;
        end
    end
endmodule : split_reload_timer
`default_nettype wire

// ==== tb/split_reload_timer_props.sv ====
// bus timing and interrupt properties of the split reload timer
`timescale 1ns/1ps
`default_nettype none
module timer_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // pin and interrupt
    input wire logic        capture_input_pin,
    input wire logic        irq
);
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic       mapped;
    // shadow of the mask, so irq can be judged without seeing inside
    always_comb begin
        mask_d = mask_q;
        if (write && !waitrequest && byteenable[0]
            && address == split_timer_pkg::IRQ_MASK_OFF) begin
            mask_d = writedata[2:0];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 3'h0;
        end else begin
            mask_q <= mask_d;
        end
    end
    assign mapped = (address inside {8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8,
                                     8'hDC, 8'hE0, 8'hE4});
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_one_wait: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("access waited too long");
    chk_idle_no_wait: assert property (!(read || write)
        |-> !waitrequest) else $error("wait without request");
    chk_read_latency: assert property ($rose(read)
        |-> waitrequest ##1 !waitrequest) else $error("read latency");
    chk_unmapped_zero: assert property (read && !waitrequest
        && !mapped |-> readdata == 32'h0) else $error("unmapped data");
    chk_ctrl_reserved: assert property (read && !waitrequest
        && address == split_timer_pkg::TIMER_CONTROL_OFF
        |-> readdata[31:8] == 24'h0 && !readdata[1])
        else $error("control reserved bit set");
    chk_data_hold: assert property (!read |=> $stable(readdata))
        else $error("read data moved");
    chk_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
        else $error("irq while all masked");
    chk_irq_fall_cause: assert property ($fell(irq) |-> $past(write))
        else $error("irq dropped with no write");
    cover property ($rose(irq));
    cover property ($fell(capture_input_pin));
    cover property (read && !waitrequest
        && address == split_timer_pkg::TIMER_COUNT_LOW_OFF);
endmodule : timer_props
bind split_reload_timer timer_props u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .capture_input_pin(capture_input_pin), .irq(irq));
`default_nettype wire

// ==== tb/tb_split_reload_timer.sv ====
// self-checking bench for the split reload timer
`timescale 1ns/1ps
`default_nettype none
module tb_split_reload_timer;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        ext_osc_clk = 1'b0;
    logic        capture_input_pin = 1'b1;
    logic        irq;
    logic [7:0]  rd;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #5 ref_clk = ~ref_clk;

    split_reload_timer u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext_osc_clk(ext_osc_clk), .capture_input_pin(capture_input_pin),
        .irq(irq));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // a hung handshake ends here rather than running forever
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic in_range(input logic [7:0] got, lo, hi);
        total_checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            fails++;
            $display("BAD %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : in_range

    // one access; a spare edge follows so strobes never rise twice at once
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, exp);
    endtask : rchk

    task automatic t_reset;
        rchk(8'hC8, 8'h00);
        rchk(8'hCC, 8'h00);
        rchk(8'hF0, 8'h00);
        // a write without byte lane 0, and one to a hole, change nothing
        byteenable <= 4'hE;
        bus(1'b1, 8'hCC, 8'h55);
        byteenable <= 4'hF;
        bus(1'b1, 8'hF0, 8'h55);
        rchk(8'hCC, 8'h00);
        rchk(8'hF0, 8'h00);
    endtask : t_reset

    task automatic t_count16;
        bus(1'b1, 8'hDC, 8'h01);
        bus(1'b1, 8'hD4, 8'h34);
        bus(1'b1, 8'hD8, 8'h12);
        bus(1'b1, 8'hCC, 8'hFE);
        bus(1'b1, 8'hD0, 8'hFF);
        bus(1'b1, 8'hC8, 8'h04);
        // the rollover edge would otherwise be the read's sampling edge
        repeat (2) @(posedge ref_clk);
        bus(1'b0, 8'hC8, 8'h00);
        check(rd & 8'hC4, 8'hC4);
        bus(1'b1, 8'hC8, 8'h00);
        rchk(8'hD0, 8'h12);
        bus(1'b1, 8'hCC, 8'h40);
        repeat (20) @(posedge ref_clk);
        rchk(8'hCC, 8'h40);
    endtask : t_count16

    task automatic t_split;
        bus(1'b1, 8'hD0, 8'h50);
        bus(1'b1, 8'hCC, 8'hFE);
        bus(1'b1, 8'hD4, 8'h80);
        bus(1'b1, 8'hD8, 8'h60);
        bus(1'b1, 8'hC8, 8'h08);
        repeat (10) @(posedge ref_clk);
        rchk(8'hD0, 8'h50);
        bus(1'b0, 8'hCC, 8'h00);
        in_range(rd, 8'h80, 8'hA0);
        bus(1'b0, 8'hC8, 8'h00);
        check(rd & 8'hC0, 8'h40);
        bus(1'b1, 8'hDC, 8'h03);
        bus(1'b1, 8'hD0, 8'hFF);
        bus(1'b1, 8'hC8, 8'h0C);
        bus(1'b0, 8'hD0, 8'h00);
        in_range(rd, 8'h60, 8'h70);
        bus(1'b0, 8'hC8, 8'h00);
        check(rd & 8'h80, 8'h80);
    endtask : t_split

    task automatic t_irq;
        bus(1'b1, 8'hC8, 8'h00);
        rchk(8'hC8, 8'h00);
        rchk(8'hE0, 8'h03);
        bus(1'b1, 8'hE4, 8'h02);
        check({7'h0, irq}, 8'h00);
        bus(1'b1, 8'hC8, 8'h20);
        check({7'h0, irq}, 8'h01);
        bus(1'b1, 8'hE4, 8'h01);
        check({7'h0, irq}, 8'h01);
        bus(1'b1, 8'hE0, 8'h01);
        check({7'h0, irq}, 8'h00);
        rchk(8'hE0, 8'h02);
        bus(1'b1, 8'hE0, 8'h02);
        rchk(8'hE0, 8'h00);
    endtask : t_irq

    task automatic t_capture;
        bus(1'b1, 8'hE4, 8'h04);
        bus(1'b1, 8'hC8, 8'h10);
        bus(1'b1, 8'hCC, 8'h77);
        bus(1'b1, 8'hD0, 8'h66);
        capture_input_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({7'h0, irq}, 8'h01);
        rchk(8'hD4, 8'h77);
        rchk(8'hD8, 8'h66);
        capture_input_pin <= 1'b1;
    endtask : t_capture

    task automatic t_clocks;
        bus(1'b1, 8'hDC, 8'h00);
        bus(1'b1, 8'hCC, 8'h00);
        bus(1'b1, 8'hC8, 8'h05);
        // no edges so far, so sixteen edges give exactly two ticks
        repeat (16) begin
            ext_osc_clk <= 1'b1;
            repeat (2) @(posedge ref_clk);
            ext_osc_clk <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        bus(1'b1, 8'hC8, 8'h01);
        rchk(8'hCC, 8'h02);
        bus(1'b1, 8'hCC, 8'h00);
        bus(1'b1, 8'hC8, 8'h04);
        repeat (120) @(posedge ref_clk);
        bus(1'b1, 8'hC8, 8'h00);
        bus(1'b0, 8'hCC, 8'h00);
        in_range(rd, 8'h09, 8'h0B);
    endtask : t_clocks

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_count16();
        t_split();
        t_irq();
        t_capture();
        t_clocks();
        give_verdict();
    end
endmodule : tb_split_reload_timer
`default_nettype wire
